// ==== src/ckgen_down_counter.v ====
// Loadable down-counter that steps on an enable pulse and flags expiry.
// Assumes i_tick is a one-cycle pulse of the single system clock.
`default_nettype none

module ckgen_down_counter #(
    parameter W = 8
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_load,
    input wire [W-1:0] i_value,
    input wire i_stop,
    input wire i_tick,
    output reg o_expired
);

    reg [W-1:0] count;
    reg running;

    // ==========================================
    // Count down; a preset of zero or one expires at the first tick
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= {W{1'b0}};
            running <= 1'b0;
            o_expired <= 1'b0;
        end else begin
            o_expired <= 1'b0;
            if (i_stop) begin
                running <= 1'b0;
            end else if (i_load) begin
                count <= i_value;
                running <= 1'b1;
            end else if (running && i_tick) begin
                if (count <= {{(W-1){1'b0}}, 1'b1}) begin
                    count <= {W{1'b0}};
                    running <= 1'b0;
                    o_expired <= 1'b1;
                end else begin
                    count <= count - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

`default_nettype wire

// ==== src/ckgen_freq_meter.v ====
// Measures the primary clock from a slow rise to the sixteenth slow fall, fifteen and a half slow-clock periods.
// Assumes edge pulses come from the system clock domain, one cycle each.
`default_nettype none
`include "ckgen_regs.vh"

module ckgen_freq_meter (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_settled,
    input wire i_slow_rise,
    input wire i_slow_fall,
    input wire i_primary_rise,
    output reg [`CKGEN_TALLY_W-1:0] o_tally,
    output reg o_done
);

    localparam ST_IDLE = 2'b00;
    localparam ST_ARM = 2'b01;
    localparam ST_COUNT = 2'b10;
    localparam ST_DONE = 2'b11;

    reg [1:0] state;
    reg [3:0] falls;

    // ==========================================
    // Measurement sequence; losing the oscillator restarts it
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= ST_IDLE;
            falls <= 4'h0;
            o_tally <= {`CKGEN_TALLY_W{1'b0}};
            o_done <= 1'b0;
        end else if (!i_settled) begin
            state <= ST_IDLE; // R17
            o_done <= 1'b0; // R17
        end else begin
            case (state)
                ST_IDLE: begin
                    o_tally <= {`CKGEN_TALLY_W{1'b0}};
                    falls <= 4'h0;
                    state <= ST_ARM;
                end
                ST_ARM: begin
                    if (i_slow_rise) begin
                        state <= ST_COUNT; // R6
                    end
                end
                ST_COUNT: begin
                    if (i_primary_rise) begin
                        o_tally <= o_tally + {{(`CKGEN_TALLY_W-1){1'b0}}, 1'b1}; // R6
                    end
                    if (i_slow_fall) begin
                        falls <= falls + 4'h1;
                        if (falls == `CKGEN_FALLS_LAST) begin
                            state <= ST_DONE; // R7
                            o_done <= 1'b1; // R7
                        end
                    end
                end
                ST_DONE: begin
                    state <= ST_DONE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ==== src/ckgen_regs.vh ====
// Register map, field positions, reset values and counter widths for the
// clock generator control block. Included by every design file of the block except the down-counter.
`ifndef CKGEN_REGS_VH
`define CKGEN_REGS_VH

// ==========================================
// Register byte offsets
`define CKGEN_ADDR_W 8
`define CKGEN_OFS_OSC 8'h00
`define CKGEN_OFS_FREQ 8'h04
`define CKGEN_OFS_PLL 8'h08
`define CKGEN_OFS_STAT 8'h0c
`define CKGEN_OFS_ISR 8'h10
`define CKGEN_OFS_IMR 8'h14

// ==========================================
// Field positions
`define CKGEN_OSC_ON_BIT 0
`define CKGEN_OSC_EXT_BIT 1
`define CKGEN_OSC_PRE_LSB 8
`define CKGEN_OSC_PRE_W 8
`define CKGEN_FREQ_DONE_BIT 16
`define CKGEN_TALLY_W 16
`define CKGEN_PLL_DIV_LSB 0
`define CKGEN_PLL_DIV_W 8
`define CKGEN_PLL_CNT_LSB 8
`define CKGEN_PLL_CNT_W 6
`define CKGEN_PLL_MUL_LSB 16
`define CKGEN_PLL_MUL_W 11
`define CKGEN_EV_SETTLED 0
`define CKGEN_EV_LOCK 1
`define CKGEN_EV_TALLY 2
`define CKGEN_EV_W 3

// ==========================================
// Reset values and timing counts
`define CKGEN_RST_OSC 8'h00
`define CKGEN_RST_DIV 8'h00
`define CKGEN_RST_MUL 11'h000
`define CKGEN_RST_PCNT 6'h00
`define CKGEN_SLOW_PRESCALE 3'h7
`define CKGEN_FALLS_LAST 4'hf

`endif

// ==== src/ckgen_top.v ====
// Clock generator control: oscillator start-up timing, frequency measure,
// bypass select, PLL divider/multiplier settings and lock timing.
// Assumes slow and primary clocks arrive as inputs synchronous to i_clk,
// which must run more than twice as fast as either of them.
//
// Function
// R1: After reset the oscillator is off and the slow clock is used.
// R2: Clearing osc_power_on clears osc_settled_flag at once.
// R3: Software picks a start-up preset that covers the crystal start-up.
// R4: Enable write clears settled flag, counts 8-bit preset down per eight slow cycles.
// R5: Counter at zero sets osc_settled_flag; unmasked it raises an interrupt.
// R6: Once settled, tally counts primary cycles after the next slow rising edge.
// R7: At sixteenth slow falling edge tally stops and xtal_tally_done sets.
// R8: For an external clock software sets external_clock_select, osc_power_on zero.
// R9: Divider ratios 1 to 255; zero forces divider and PLL outputs low.
// R10: pll_prescale_ratio resets to zero, holding the PLL input low.
// R11: PLL output is source times (pll_gain_factor plus one) over prescale ratio.
// R12: Gain factor zero disables the PLL; nonzero enables it again.
// R13: Re-enabling the PLL or rewriting its parameters clears the lock flag.
// R14: PLL write loads settle preset, counts down per slow cycle, then locks.
// R15: Software picks a settle preset covering the PLL transient time.
// R16: Gain factor accepts 0 to 2047, an 11-bit field.
// R17: Tally done clears and measurement restarts when settled flag drops.
`default_nettype none
`include "ckgen_regs.vh"

module ckgen_top (
    input wire i_clk,
    input wire i_arst_n,
    input wire [`CKGEN_ADDR_W-1:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    input wire i_slow_clk,
    input wire i_primary_clk,
    output wire o_osc_power_on,
    output wire o_external_clock_select,
    output wire o_primary_clk_valid,
    output wire [`CKGEN_PLL_DIV_W-1:0] o_pll_prescale_ratio,
    output wire [`CKGEN_PLL_MUL_W:0] o_pll_mult_factor,
    output wire o_pll_enable,
    output wire o_synth_clk_force_low,
    output wire o_pll_locked,
    output wire o_irq
);

    // ==========================================
    // Bus slave: one wait state on every access
    reg ack;
    wire bus_req = i_avs_read | i_avs_write;
    wire wr_en = i_avs_write & ack;

    assign o_avs_waitrequest = bus_req & ~ack;

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= bus_req & ~ack;
        end
    end

    // Write strobe decode, used for each writable register
    function wr_hit;
        input [`CKGEN_ADDR_W-1:0] adr;
        input [`CKGEN_ADDR_W-1:0] ofs;
        begin
            wr_hit = (adr == ofs);
        end
    endfunction

    wire wr_osc = wr_en & wr_hit(i_avs_address, `CKGEN_OFS_OSC);
    wire wr_pll = wr_en & wr_hit(i_avs_address, `CKGEN_OFS_PLL);
    wire wr_isr = wr_en & wr_hit(i_avs_address, `CKGEN_OFS_ISR);
    wire wr_imr = wr_en & wr_hit(i_avs_address, `CKGEN_OFS_IMR);

    // ==========================================
    // Slow and primary clock edge detection
    reg slow_q;
    reg primary_q;
    wire slow_rise = i_slow_clk & ~slow_q;
    wire slow_fall = ~i_slow_clk & slow_q;
    wire primary_rise = i_primary_clk & ~primary_q;

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            slow_q <= 1'b0;
            primary_q <= 1'b0;
        end else begin
            slow_q <= i_slow_clk;
            primary_q <= i_primary_clk;
        end
    end

    // ==========================================
    // Oscillator control register
    reg osc_power_on;
    reg external_clock_select;
    reg [`CKGEN_OSC_PRE_W-1:0] osc_startup_preset;
    wire next_power_on = i_avs_writedata[`CKGEN_OSC_ON_BIT];

    // Oscillator stays off after reset so start-up draws little power
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            osc_power_on <= 1'b0; // R1
            external_clock_select <= 1'b0;
            osc_startup_preset <= `CKGEN_RST_OSC;
        end else if (wr_osc) begin
            osc_power_on <= next_power_on;
            external_clock_select <= i_avs_writedata[`CKGEN_OSC_EXT_BIT];
            osc_startup_preset <= i_avs_writedata[`CKGEN_OSC_PRE_LSB +: `CKGEN_OSC_PRE_W];
        end
    end

    // Analog enable is withheld in bypass so an external clock is not loaded
    assign o_osc_power_on = osc_power_on & ~external_clock_select; // R8
    assign o_external_clock_select = external_clock_select;

    // ==========================================
    // Slow clock divided by eight, restarted by each enable write
    reg [2:0] slow_div;
    wire osc_start = wr_osc & next_power_on;
    wire slow_div8 = slow_rise & (slow_div == `CKGEN_SLOW_PRESCALE);

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            slow_div <= 3'h0;
        end else if (osc_start) begin
            slow_div <= 3'h0; // R4
        end else if (slow_rise) begin
            slow_div <= slow_div + 3'h1; // R4
        end
    end

    // ==========================================
    // Oscillator start-up timer and settled flag
    wire osc_expired;
    reg osc_settled_flag;

    ckgen_down_counter #(
        .W(`CKGEN_OSC_PRE_W)
    ) u_osc_timer (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_load(osc_start),
        .i_value(i_avs_writedata[`CKGEN_OSC_PRE_LSB +: `CKGEN_OSC_PRE_W]),
        .i_stop(wr_osc & ~next_power_on),
        .i_tick(slow_div8),
        .o_expired(osc_expired)
    );

    // Any oscillator write drops the flag; only expiry raises it again
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            osc_settled_flag <= 1'b0;
        end else if (wr_osc) begin
            osc_settled_flag <= 1'b0; // R2 R4
        end else if (osc_expired) begin
            osc_settled_flag <= 1'b1; // R5
        end
    end

    assign o_primary_clk_valid = osc_settled_flag;

    // ==========================================
    // Primary clock frequency measurement
    wire [`CKGEN_TALLY_W-1:0] xtal_cycle_tally;
    wire xtal_tally_done;
    reg tally_done_q;

    ckgen_freq_meter u_meter (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_settled(osc_settled_flag),
        .i_slow_rise(slow_rise),
        .i_slow_fall(slow_fall),
        .i_primary_rise(primary_rise),
        .o_tally(xtal_cycle_tally),
        .o_done(xtal_tally_done)
    );

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tally_done_q <= 1'b0;
        end else begin
            tally_done_q <= xtal_tally_done;
        end
    end

    // ==========================================
    // PLL configuration register
    reg [`CKGEN_PLL_DIV_W-1:0] pll_prescale_ratio;
    reg [`CKGEN_PLL_MUL_W-1:0] pll_gain_factor;
    reg [`CKGEN_PLL_CNT_W-1:0] pll_settle_preset;

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pll_prescale_ratio <= `CKGEN_RST_DIV; // R10
            pll_gain_factor <= `CKGEN_RST_MUL;
            pll_settle_preset <= `CKGEN_RST_PCNT;
        end else if (wr_pll) begin
            pll_prescale_ratio <= i_avs_writedata[`CKGEN_PLL_DIV_LSB +: `CKGEN_PLL_DIV_W]; // R9
            pll_gain_factor <= i_avs_writedata[`CKGEN_PLL_MUL_LSB +: `CKGEN_PLL_MUL_W]; // R16
            pll_settle_preset <= i_avs_writedata[`CKGEN_PLL_CNT_LSB +: `CKGEN_PLL_CNT_W];
        end
    end

    // Ratio goes straight to the analog synthesiser, factor as gain plus one
    assign o_pll_prescale_ratio = pll_prescale_ratio; // R11
    assign o_pll_mult_factor = {1'b0, pll_gain_factor} + {{`CKGEN_PLL_MUL_W{1'b0}}, 1'b1}; // R11
    assign o_pll_enable = (pll_gain_factor != `CKGEN_RST_MUL); // R12
    assign o_synth_clk_force_low = (pll_prescale_ratio == `CKGEN_RST_DIV) | ~o_pll_enable; // R9 R12

    // ==========================================
    // PLL lock timer and lock flag
    wire pll_expired;
    reg pll_lock_flag;

    ckgen_down_counter #(
        .W(`CKGEN_PLL_CNT_W)
    ) u_pll_timer (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_load(wr_pll),
        .i_value(i_avs_writedata[`CKGEN_PLL_CNT_LSB +: `CKGEN_PLL_CNT_W]),
        .i_stop(1'b0),
        .i_tick(slow_rise),
        .o_expired(pll_expired)
    );

    // A stopped synthesiser never reports lock
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pll_lock_flag <= 1'b0;
        end else if (wr_pll) begin
            pll_lock_flag <= 1'b0; // R13
        end else if (pll_expired && !o_synth_clk_force_low) begin
            pll_lock_flag <= 1'b1; // R14
        end
    end

    assign o_pll_locked = pll_lock_flag;

    // ==========================================
    // Sticky event status with write-one-to-clear and mask
    reg [`CKGEN_EV_W-1:0] int_status;
    reg [`CKGEN_EV_W-1:0] int_mask;
    wire [`CKGEN_EV_W-1:0] events;

    assign events[`CKGEN_EV_SETTLED] = osc_expired & ~wr_osc;
    assign events[`CKGEN_EV_LOCK] = pll_expired & ~wr_pll & ~o_synth_clk_force_low;
    assign events[`CKGEN_EV_TALLY] = xtal_tally_done & ~tally_done_q;

    // Set wins over a clear in the same cycle so no event is lost
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            int_status <= {`CKGEN_EV_W{1'b0}};
            int_mask <= {`CKGEN_EV_W{1'b0}};
        end else begin
            int_status <= (int_status & ~({`CKGEN_EV_W{wr_isr}} & i_avs_writedata[`CKGEN_EV_W-1:0])) | events;
            if (wr_imr) begin
                int_mask <= i_avs_writedata[`CKGEN_EV_W-1:0];
            end
        end
    end

    assign o_irq = |(int_status & int_mask); // R5 R14

    // ==========================================
    // Read data, captured on the first cycle of a read
    reg [31:0] next_rdata;

    always @* begin
        next_rdata = 32'h0000_0000;
        case (i_avs_address)
            `CKGEN_OFS_OSC: begin
                next_rdata[`CKGEN_OSC_ON_BIT] = osc_power_on;
                next_rdata[`CKGEN_OSC_EXT_BIT] = external_clock_select;
                next_rdata[`CKGEN_OSC_PRE_LSB +: `CKGEN_OSC_PRE_W] = osc_startup_preset;
            end
            `CKGEN_OFS_FREQ: begin
                next_rdata[`CKGEN_TALLY_W-1:0] = xtal_cycle_tally;
                next_rdata[`CKGEN_FREQ_DONE_BIT] = xtal_tally_done;
            end
            `CKGEN_OFS_PLL: begin
                next_rdata[`CKGEN_PLL_DIV_LSB +: `CKGEN_PLL_DIV_W] = pll_prescale_ratio;
                next_rdata[`CKGEN_PLL_CNT_LSB +: `CKGEN_PLL_CNT_W] = pll_settle_preset;
                next_rdata[`CKGEN_PLL_MUL_LSB +: `CKGEN_PLL_MUL_W] = pll_gain_factor;
            end
            `CKGEN_OFS_STAT: begin
                next_rdata[`CKGEN_EV_SETTLED] = osc_settled_flag;
                next_rdata[`CKGEN_EV_LOCK] = pll_lock_flag;
                next_rdata[`CKGEN_EV_TALLY] = xtal_tally_done;
            end
            `CKGEN_OFS_ISR: begin
                next_rdata[`CKGEN_EV_W-1:0] = int_status;
            end
            `CKGEN_OFS_IMR: begin
                next_rdata[`CKGEN_EV_W-1:0] = int_mask;
            end
            default: begin
                next_rdata = 32'h0000_0000; // Unmapped reads as zero
            end
        endcase
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && !ack) begin
            o_avs_readdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// ==== verification/ckgen_checker.sv ====
// Port-level assertions for the clock generator control block.
// Assumes one clock domain and the asynchronous active-low reset.
`default_nettype none
`include "ckgen_regs.vh"

module ckgen_checker (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [`CKGEN_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic o_avs_waitrequest,
    input wire logic o_osc_power_on,
    input wire logic o_external_clock_select,
    input wire logic o_primary_clk_valid,
    input wire logic [`CKGEN_PLL_DIV_W-1:0] o_pll_prescale_ratio,
    input wire logic [`CKGEN_PLL_MUL_W:0] o_pll_mult_factor,
    input wire logic o_pll_enable,
    input wire logic o_synth_clk_force_low,
    input wire logic o_pll_locked
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================
    // Writes that complete at this edge
    wire logic osc_wr;
    wire logic pll_wr;
    assign osc_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == `CKGEN_OFS_OSC;
    assign pll_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == `CKGEN_OFS_PLL;

    default clocking dc @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    // ==========================================
    // Properties
    AST_OSC_OFF_RST: assert property ($rose(i_arst_n) |-> !o_osc_power_on && !o_primary_clk_valid)
        else $error("oscillator active right after reset");
    AST_OFF_CLEARS: assert property (osc_wr && !i_avs_writedata[0] |=> !o_primary_clk_valid)
        else $error("settled flag kept after oscillator off");
    AST_START_HOLD: assert property (osc_wr && i_avs_writedata[0] |=> !o_primary_clk_valid [*8])
        else $error("settled flag too early after enable");
    AST_SETTLE_SRC: assert property ($rose(o_primary_clk_valid) |-> o_osc_power_on || o_external_clock_select)
        else $error("settled flag rose with oscillator off");
    AST_FORCE_LOW: assert property (o_synth_clk_force_low == (o_pll_prescale_ratio == 0 || !o_pll_enable))
        else $error("force low disagrees with divider or gain");
    AST_GAIN_EN: assert property (o_pll_enable == (o_pll_mult_factor > 12'h001))
        else $error("pll enable disagrees with gain");
    AST_GAIN_WR: assert property (pll_wr |=> o_pll_mult_factor == $past(i_avs_writedata[26:16]) + 12'h001)
        else $error("multiplier not gain plus one");
    AST_LOCK_CLR: assert property (pll_wr |=> !o_pll_locked)
        else $error("lock kept after pll write");
    AST_LOCK_SRC: assert property ($rose(o_pll_locked) |-> !o_synth_clk_force_low && $stable(o_pll_prescale_ratio))
        else $error("lock rose while pll forced off");
    AST_ONE_WAIT: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("more than one wait state");
endmodule

bind ckgen_top ckgen_checker u_ckgen_checker (.i_clk, .i_arst_n, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .o_avs_waitrequest, .o_osc_power_on, .o_external_clock_select, .o_primary_clk_valid,
    .o_pll_prescale_ratio, .o_pll_mult_factor, .o_pll_enable, .o_synth_clk_force_low, .o_pll_locked);
`default_nettype wire

// ==== verification/ckgen_top_bench.sv ====
// Self-checking bench for the clock generator control block.
// Assumes design and checker compiled first; slow and primary clocks made here.
`default_nettype none
`include "ckgen_regs.vh"

module ckgen_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_arst_n = 0, i_avs_read = 0, i_avs_write = 0, i_slow_clk = 0, i_primary_clk = 0;
    logic [7:0] i_avs_address = 8'h00;
    logic [31:0] i_avs_writedata = 32'h0;
    wire [31:0] o_avs_readdata;
    wire [7:0] o_pll_prescale_ratio;
    wire [11:0] o_pll_mult_factor;
    wire o_avs_waitrequest, o_osc_power_on, o_external_clock_select, o_primary_clk_valid;
    wire o_pll_enable, o_synth_clk_force_low, o_pll_locked, o_irq;
    int err_total = 0, num_checks = 0, seed = 7, ph = 2, pcnt = 0, n, c, t;
    logic [1:0] sdiv = 2'h0;
    logic [31:0] exp_q[$], msk_q[$], last_rd, m;
    logic [7:0] dv [4] = '{8'hff, 8'h01, 8'h00, 8'h03};
    logic [10:0] gn [4] = '{11'h7ff, 11'h001, 11'h005, 11'h000};

    ckgen_top u_ckgen_top (.i_clk, .i_arst_n, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
        .o_avs_readdata, .o_avs_waitrequest, .i_slow_clk, .i_primary_clk, .o_osc_power_on,
        .o_external_clock_select, .o_primary_clk_valid, .o_pll_prescale_ratio, .o_pll_mult_factor,
        .o_pll_enable, .o_synth_clk_force_low, .o_pll_locked, .o_irq);

    // ==========================================
    // Clocks: slow period 8 cycles, primary 2*ph cycles
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        sdiv <= sdiv + 2'h1;
        if (sdiv == 2'h3) i_slow_clk <= ~i_slow_clk;
        pcnt <= (pcnt >= ph - 1) ? 0 : pcnt + 1;
        if (pcnt >= ph - 1) i_primary_clk <= ~i_primary_clk;
    end

    // ==========================================
    // Reporting
    task automatic check_word(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_pin(input logic [31:0] got, exp);
        check_word(got, exp);
    endtask
    task automatic summarize;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic give_up;
        err_total++;
        summarize();
    endtask

    // ==========================================
    // Bus master; request held until waitrequest is seen low at a rising edge
    task automatic bus_req(input logic rd, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_clk);
        i_avs_read <= rd;
        i_avs_write <= !rd;
        i_avs_address <= a;
        i_avs_writedata <= d;
        do begin
            @(posedge i_clk);
            k++;
            if (k > 50) give_up();
        end while (o_avs_waitrequest);
        if (rd) last_rd = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_req(1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, mk);
        exp_q.push_back(e);
        msk_q.push_back(mk);
        bus_req(1'b1, a, 32'h0);
    endtask
    task automatic wait_sig(input bit lock, output int cnt);
        cnt = 0;
        while ((lock ? o_pll_locked : o_primary_clk_valid) !== 1'b1) begin
            @(negedge i_clk);
            cnt++;
            if (cnt > 3000) give_up();
        end
    endtask

    // Read data monitor, taken at the rising edge that completes the read
    always @(posedge i_clk) begin
        if (i_avs_read && !o_avs_waitrequest) begin
            m = msk_q.pop_front();
            check_word(o_avs_readdata & m, exp_q.pop_front() & m);
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        ph = 2 + ($unsigned($random(seed)) % 3);
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0, 32'hffffffff);
        check_pin(o_synth_clk_force_low, 1);
        check_pin(o_pll_mult_factor, 1);
        // Start-up timing with random preset, interrupt unmasked
        wr(`CKGEN_OFS_IMR, 32'h1);
        c = 1 + ($unsigned($random(seed)) % 3);
        wr(`CKGEN_OFS_OSC, (c << 8) | 32'h1);
        wait_sig(1'b0, n);
        check_pin(n >= 64 * c - 10 && n <= 64 * c + 4, 1);
        repeat (2) @(negedge i_clk);
        check_pin(o_irq, 1);
        // Fifteen and a half slow periods of measurement
        repeat (200) @(posedge i_clk);
        rd(`CKGEN_OFS_FREQ, 32'h10000, 32'h10000);
        t = last_rd[15:0] * 2 * ph;
        check_pin(t >= 124 - 4 * ph && t <= 128 + 4 * ph, 1);
        rd(`CKGEN_OFS_STAT, 32'h5, 32'h5);
        rd(`CKGEN_OFS_ISR, 32'h5, 32'h7);
        wr(`CKGEN_OFS_ISR, 32'h7);
        @(negedge i_clk);
        check_pin(o_irq, 0);
        wr(`CKGEN_OFS_IMR, 32'h2);
        rd(`CKGEN_OFS_ISR, 32'h0, 32'h7);
        // Oscillator off, then bypass
        wr(`CKGEN_OFS_OSC, 32'h0);
        @(negedge i_clk);
        check_pin(o_primary_clk_valid, 0);
        rd(`CKGEN_OFS_FREQ, 32'h0, 32'h10000);
        wr(`CKGEN_OFS_OSC, 32'h2);
        @(negedge i_clk);
        check_pin(o_external_clock_select, 1);
        check_pin(o_osc_power_on, 0);
        // Divider and gain table, lock timing
        for (int k = 0; k < 4; k++) begin
            c = 1 + ($unsigned($random(seed)) % 4);
            wr(`CKGEN_OFS_PLL, {5'h0, gn[k], 2'h0, c[5:0], dv[k]});
            @(negedge i_clk);
            check_pin(o_pll_locked, 0);
            check_pin(o_pll_prescale_ratio, dv[k]);
            check_pin(o_pll_mult_factor, gn[k] + 12'h001);
            check_pin(o_pll_enable, gn[k] != 0);
            check_pin(o_synth_clk_force_low, dv[k] == 0 || gn[k] == 0);
            if (dv[k] != 0 && gn[k] != 0) begin
                wait_sig(1'b1, n);
                check_pin(n >= 8 * c - 10 && n <= 8 * c + 4, 1);
                check_pin(o_irq, 1);
            end else begin
                repeat (80) @(negedge i_clk);
                check_pin(o_pll_locked, 0);
            end
        end
        rd(`CKGEN_OFS_ISR, 32'h2, 32'h2);
        summarize();
    end
endmodule
`default_nettype wire
